// [dct_timer_regs.sv]
`default_nettype none
module dct_timer_regs (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	// register port
	input  wire dct_pkg::dct_bus_req_type busReq,
	output logic [7:0]                    busRdata,
	// channel pins, index unit*2+channel
	input  wire logic [3:0]               chPinIn,
	output logic [3:0]                    chPinOut,
	output logic [3:0]                    chPinOe,
	// interrupt requests
	output logic [1:0]                    overflowIrq,
	output logic [3:0]                    channelIrq
);
	localparam logic [7:0] UNIT_BASE [dct_pkg::TIMERS] = '{dct_pkg::UNIT0_BASE, dct_pkg::UNIT1_BASE};

	dct_pkg::dct_state_type s;
	dct_pkg::dct_state_type next_s;

	logic [7:0]  off;
	logic        wr;
	logic        rd;
	logic [6:0]  divOne;
	logic [5:0]  divMask;
	logic        tick;
	logic        wrap;
	logic        ovfSet;
	logic [7:0]  chBase;
	logic        disabled;
	logic        compareMode;
	logic        captureMode;
	logic        stable;
	logic        newLevel;
	logic        rise;
	logic        fall;
	logic        edgeHit;
	logic        match;
	logic        chSet;
	logic [15:0] cmpValue;

	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;
		off = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		divOne = 7'h00;
		divMask = 6'h00;
		tick = 1'b0;
		wrap = 1'b0;
		ovfSet = 1'b0;
		chBase = 8'h00;
		disabled = 1'b0;
		compareMode = 1'b0;
		captureMode = 1'b0;
		stable = 1'b0;
		newLevel = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		edgeHit = 1'b0;
		match = 1'b0;
		chSet = 1'b0;
		cmpValue = 16'h0000;
		for (int t = 0; t < dct_pkg::TIMERS; t++) begin
			off = 8'(busReq.addr - UNIT_BASE[t]);
			wr = busReq.wr && (off < dct_pkg::REG_SPAN);
			rd = busReq.rd && (off < dct_pkg::REG_SPAN);

			// prescaler and counter
			divOne = 7'h01 << s.unit[t].prescaleSelect;
			divMask = 6'(divOne - 7'h01);
			tick = !s.unit[t].countHalt && (s.unit[t].prescaleSelect != dct_pkg::PS_NONE)
				&& ((s.unit[t].prescaler & divMask) == divMask);
			if (!s.unit[t].countHalt) begin
				next_s.unit[t].prescaler = s.unit[t].prescaler + 6'h01;
			end
			wrap = tick && (s.unit[t].count == s.unit[t].wrapLimit);
			if (wrap) begin
				next_s.unit[t].count = dct_pkg::COUNT_ZERO;
			end else if (tick) begin
				next_s.unit[t].count = s.unit[t].count + 16'h0001;
			end
			ovfSet = wrap && !s.unit[t].wrapPending;
			if (wrap) begin
				next_s.unit[t].bufActive = s.unit[t].bufNext;
			end

			// overflow flag: set wins over the clearing write
			if (ovfSet) begin
				next_s.unit[t].overflowFlag = 1'b1;
				next_s.unit[t].overflowArm = 1'b0;
			end

			// main status and control
			if (rd && off == dct_pkg::OFS_MAIN_SC) begin
				next_s.rdata = {s.unit[t].overflowFlag, s.unit[t].overflowIrqEnable, s.unit[t].countHalt,
					1'b0, 1'b0, s.unit[t].prescaleSelect};
				if (s.unit[t].overflowFlag && !ovfSet) begin
					next_s.unit[t].overflowArm = 1'b1;
				end
			end
			if (wr && off == dct_pkg::OFS_MAIN_SC) begin
				next_s.unit[t].overflowIrqEnable = busReq.wdata[dct_pkg::SC_IE];
				next_s.unit[t].countHalt = busReq.wdata[dct_pkg::SC_HALT];
				next_s.unit[t].prescaleSelect = busReq.wdata[dct_pkg::PS_MSB:dct_pkg::PS_LSB];
				if (!busReq.wdata[dct_pkg::SC_FLAG] && s.unit[t].overflowArm && !ovfSet) begin
					next_s.unit[t].overflowFlag = 1'b0;
				end
				if (!ovfSet) begin
					next_s.unit[t].overflowArm = 1'b0;
				end
				if (busReq.wdata[dct_pkg::SC_RST]) begin
					// halt in the same write keeps the zeroed count frozen
					next_s.unit[t].count = dct_pkg::COUNT_ZERO;
					next_s.unit[t].prescaler = 6'h00;
				end
			end

			// count value, latched low byte
			if (rd && off == dct_pkg::OFS_CNT_HIGH) begin
				next_s.rdata = s.unit[t].count[15:8];
				if (!s.unit[t].lowLatched) begin
					next_s.unit[t].lowBuffer = s.unit[t].count[7:0];
					next_s.unit[t].lowLatched = 1'b1;
				end
			end
			if (rd && off == dct_pkg::OFS_CNT_LOW) begin
				next_s.rdata = s.unit[t].lowLatched ? s.unit[t].lowBuffer : s.unit[t].count[7:0];
				next_s.unit[t].lowLatched = 1'b0;
			end

			// wrap limit
			if (rd && off == dct_pkg::OFS_MOD_HIGH) begin
				next_s.rdata = s.unit[t].wrapLimit[15:8];
			end
			if (rd && off == dct_pkg::OFS_MOD_LOW) begin
				next_s.rdata = s.unit[t].wrapLimit[7:0];
			end
			if (wr && off == dct_pkg::OFS_MOD_HIGH) begin
				next_s.unit[t].wrapLimit[15:8] = busReq.wdata;
				next_s.unit[t].wrapPending = 1'b1;
			end
			if (wr && off == dct_pkg::OFS_MOD_LOW) begin
				next_s.unit[t].wrapLimit[7:0] = busReq.wdata;
				next_s.unit[t].wrapPending = 1'b0;
			end

			// channels
			for (int c = 0; c < dct_pkg::CHANNELS; c++) begin
				chBase = 8'(dct_pkg::OFS_CH_SC + dct_pkg::CH_STRIDE * 8'(c));
				disabled = (c == 1) && s.unit[t].ch[0].bufferedMode;
				compareMode = s.unit[t].ch[c].bufferedMode || s.unit[t].ch[c].lowModeSelect;
				captureMode = !compareMode && (s.unit[t].ch[c].edgeLevelSelect != dct_pkg::ELS_OFF);

				// pin filter: only the second and third stages are compared
				next_s.unit[t].ch[c].syncA = chPinIn[t * dct_pkg::CHANNELS + c];
				next_s.unit[t].ch[c].syncB = s.unit[t].ch[c].syncA;
				next_s.unit[t].ch[c].syncC = s.unit[t].ch[c].syncB;
				stable = s.unit[t].ch[c].syncB == s.unit[t].ch[c].syncC;
				newLevel = stable ? s.unit[t].ch[c].syncC : s.unit[t].ch[c].pinLevel;
				next_s.unit[t].ch[c].pinLevel = newLevel;
				rise = newLevel && !s.unit[t].ch[c].pinLevel;
				fall = !newLevel && s.unit[t].ch[c].pinLevel;
				case (s.unit[t].ch[c].edgeLevelSelect)
					dct_pkg::ELS_RISE: edgeHit = rise;
					dct_pkg::ELS_FALL: edgeHit = fall;
					dct_pkg::ELS_ANY:  edgeHit = rise || fall;
					default:           edgeHit = 1'b0;
				endcase

				// buffered channel 0 switches at each wrap to whichever value set was written last
				cmpValue = (c == 0 && s.unit[t].ch[0].bufferedMode && s.unit[t].bufActive)
					? s.unit[t].ch[1].value : s.unit[t].ch[c].value;
				match = tick && compareMode && !s.unit[t].ch[c].valueLock && s.unit[t].count == cmpValue;
				chSet = !disabled && ((captureMode && edgeHit) || match);
				if (!disabled && captureMode && edgeHit && !s.unit[t].ch[c].valueLock) begin
					next_s.unit[t].ch[c].value = s.unit[t].count;
				end

				// pin drive
				next_s.unit[t].ch[c].pinOe = !disabled && compareMode
					&& (s.unit[t].ch[c].edgeLevelSelect != dct_pkg::ELS_OFF);
				if (s.unit[t].ch[c].edgeLevelSelect == dct_pkg::ELS_OFF) begin
					next_s.unit[t].ch[c].pinOut = !s.unit[t].ch[c].lowModeSelect;
				end else if (compareMode && s.unit[t].ch[c].overflowToggle && s.unit[t].ch[c].maxDuty) begin
					next_s.unit[t].ch[c].pinOut = 1'b1;
				end else if (compareMode && wrap && s.unit[t].ch[c].overflowToggle) begin
					// overflow toggle outranks a coincident compare
					next_s.unit[t].ch[c].pinOut = !s.unit[t].ch[c].pinOut;
				end else if (match) begin
					case (s.unit[t].ch[c].edgeLevelSelect)
						dct_pkg::ELS_RISE: next_s.unit[t].ch[c].pinOut = !s.unit[t].ch[c].pinOut;
						dct_pkg::ELS_FALL: next_s.unit[t].ch[c].pinOut = 1'b0;
						default:           next_s.unit[t].ch[c].pinOut = 1'b1;
					endcase
				end

				if (chSet) begin
					next_s.unit[t].ch[c].eventFlag = 1'b1;
					next_s.unit[t].ch[c].clearArm = 1'b0;
				end

				// channel status and control
				if (rd && off == chBase && !disabled) begin
					next_s.rdata = {s.unit[t].ch[c].eventFlag, s.unit[t].ch[c].irqEnable,
						s.unit[t].ch[c].bufferedMode, s.unit[t].ch[c].lowModeSelect,
						s.unit[t].ch[c].edgeLevelSelect, s.unit[t].ch[c].overflowToggle,
						s.unit[t].ch[c].maxDuty};
					if (s.unit[t].ch[c].eventFlag && !chSet) begin
						next_s.unit[t].ch[c].clearArm = 1'b1;
					end
				end
				if (wr && off == chBase && !disabled) begin
					next_s.unit[t].ch[c].irqEnable = busReq.wdata[dct_pkg::CS_IE];
					if (c == 0) begin
						next_s.unit[t].ch[c].bufferedMode = busReq.wdata[dct_pkg::CS_MSB];
					end
					next_s.unit[t].ch[c].lowModeSelect = busReq.wdata[dct_pkg::CS_MSA];
					next_s.unit[t].ch[c].edgeLevelSelect = busReq.wdata[dct_pkg::ELS_MSB:dct_pkg::ELS_LSB];
					next_s.unit[t].ch[c].overflowToggle = busReq.wdata[dct_pkg::CS_TOV];
					next_s.unit[t].ch[c].maxDuty = busReq.wdata[dct_pkg::CS_MAX];
					if (!busReq.wdata[dct_pkg::CS_FLAG] && s.unit[t].ch[c].clearArm && !chSet) begin
						next_s.unit[t].ch[c].eventFlag = 1'b0;
					end
					if (!chSet) begin
						next_s.unit[t].ch[c].clearArm = 1'b0;
					end
				end

				// channel value: a high write, or a high read in capture mode, locks until the low byte completes it
				if (rd && off == 8'(chBase + 8'h01)) begin
					next_s.rdata = s.unit[t].ch[c].value[15:8];
					if (captureMode) begin
						next_s.unit[t].ch[c].valueLock = 1'b1;
					end
				end
				if (rd && off == 8'(chBase + 8'h02)) begin
					next_s.rdata = s.unit[t].ch[c].value[7:0];
					if (captureMode) begin
						next_s.unit[t].ch[c].valueLock = 1'b0;
					end
				end
				if (wr && off == 8'(chBase + 8'h01)) begin
					next_s.unit[t].ch[c].value[15:8] = busReq.wdata;
					next_s.unit[t].ch[c].valueLock = 1'b1;
				end
				if (wr && off == 8'(chBase + 8'h02)) begin
					next_s.unit[t].ch[c].value[7:0] = busReq.wdata;
					next_s.unit[t].ch[c].valueLock = 1'b0;
					next_s.unit[t].bufNext = (c == 1);
				end

				next_s.unit[t].ch[c].irq = !disabled && next_s.unit[t].ch[c].eventFlag
					&& next_s.unit[t].ch[c].irqEnable;
			end

			next_s.unit[t].irq = next_s.unit[t].overflowFlag && next_s.unit[t].overflowIrqEnable;
		end

		if (sys_rst) begin
			next_s = '0;
			for (int t = 0; t < dct_pkg::TIMERS; t++) begin
				next_s.unit[t].countHalt = 1'b1;
				next_s.unit[t].wrapLimit = dct_pkg::MOD_RESET;
				next_s.unit[t].count = dct_pkg::COUNT_ZERO;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		s <= next_s;
	end

	assign busRdata = s.rdata;
	for (genvar t = 0; t < dct_pkg::TIMERS; t++) begin : g_unit
		assign overflowIrq[t] = s.unit[t].irq;
		for (genvar c = 0; c < dct_pkg::CHANNELS; c++) begin : g_chan
			assign chPinOut[t * dct_pkg::CHANNELS + c] = s.unit[t].ch[c].pinOut;
			assign chPinOe[t * dct_pkg::CHANNELS + c] = s.unit[t].ch[c].pinOe;
			assign channelIrq[t * dct_pkg::CHANNELS + c] = s.unit[t].ch[c].irq;
		end
	end
endmodule
`default_nettype wire

// [dct_pkg.sv]
`default_nettype none
package dct_pkg;
	localparam int TIMERS   = 2;
	localparam int CHANNELS = 2;

	// register window of each timer unit; unit 0 base, unit 1 base
	localparam logic [7:0] UNIT0_BASE = 8'h20;
	localparam logic [7:0] UNIT1_BASE = 8'h2b;
	localparam logic [7:0] REG_SPAN   = 8'h0b;

	// offsets inside a unit window
	localparam logic [7:0] OFS_MAIN_SC  = 8'h00;
	localparam logic [7:0] OFS_CNT_HIGH = 8'h01;
	localparam logic [7:0] OFS_CNT_LOW  = 8'h02;
	localparam logic [7:0] OFS_MOD_HIGH = 8'h03;
	localparam logic [7:0] OFS_MOD_LOW  = 8'h04;
	localparam logic [7:0] OFS_CH_SC    = 8'h05;
	localparam logic [7:0] OFS_CH_HIGH  = 8'h06;
	localparam logic [7:0] OFS_CH_LOW   = 8'h07;
	localparam logic [7:0] CH_STRIDE    = 8'h03;

	// main status and control fields
	localparam int SC_FLAG = 7;
	localparam int SC_IE   = 6;
	localparam int SC_HALT = 5;
	localparam int SC_RST  = 4;
	localparam int PS_MSB  = 2;
	localparam int PS_LSB  = 0;

	// channel status and control fields
	localparam int CS_FLAG = 7;
	localparam int CS_IE   = 6;
	localparam int CS_MSB  = 5;
	localparam int CS_MSA  = 4;
	localparam int ELS_MSB = 3;
	localparam int ELS_LSB = 2;
	localparam int CS_TOV  = 1;
	localparam int CS_MAX  = 0;

	localparam logic [2:0]  PS_NONE     = 3'h7;
	localparam logic [15:0] MOD_RESET   = 16'hffff;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;
	localparam logic [1:0]  ELS_OFF     = 2'h0;
	localparam logic [1:0]  ELS_RISE    = 2'h1;
	localparam logic [1:0]  ELS_FALL    = 2'h2;
	localparam logic [1:0]  ELS_ANY     = 2'h3;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dct_bus_req_type;

	typedef struct packed {
		logic        eventFlag;
		logic        clearArm;
		logic        irqEnable;
		logic        bufferedMode;
		logic        lowModeSelect;
		logic [1:0]  edgeLevelSelect;
		logic        overflowToggle;
		logic        maxDuty;
		logic [15:0] value;
		logic        valueLock;
		logic        syncA;
		logic        syncB;
		logic        syncC;
		logic        pinLevel;
		logic        pinOut;
		logic        pinOe;
		logic        irq;
	} dct_chan_type;

	typedef struct packed {
		logic                        overflowFlag;
		logic                        overflowArm;
		logic                        overflowIrqEnable;
		logic                        countHalt;
		logic [2:0]                  prescaleSelect;
		logic [5:0]                  prescaler;
		logic [15:0]                 count;
		logic [7:0]                  lowBuffer;
		logic                        lowLatched;
		logic [15:0]                 wrapLimit;
		logic                        wrapPending;
		logic                        bufActive;
		logic                        bufNext;
		logic                        irq;
		dct_chan_type [CHANNELS-1:0] ch;
	} dct_unit_type;

	typedef struct packed {
		dct_unit_type [TIMERS-1:0] unit;
		logic [7:0]                rdata;
	} dct_state_type;
endpackage
`default_nettype wire

// [dct_timer_regs_props.sv]
`default_nettype none
module dct_timer_regs_props (
	// clock and reset
	input wire logic                     core_clk,
	input wire logic                     sys_rst,
	// register port
	input wire dct_pkg::dct_bus_req_type busReq,
	input wire logic [7:0]               busRdata,
	// pins and requests
	input wire logic [3:0]               chPinIn,
	input wire logic [3:0]               chPinOut,
	input wire logic [3:0]               chPinOe,
	input wire logic [1:0]               overflowIrq,
	input wire logic [3:0]               channelIrq
);
	logic [1:0] ovIe;
	logic [3:0] chIe;
	logic [1:0] bufMode;
	logic [7:0] ofs [2];
	logic       wrMain0;
	logic       wrCh0;
	assign ofs[0] = busReq.addr - dct_pkg::UNIT0_BASE;
	assign ofs[1] = busReq.addr - dct_pkg::UNIT1_BASE;
	assign wrMain0 = busReq.wr && busReq.addr == dct_pkg::UNIT0_BASE;
	assign wrCh0 = busReq.wr && ofs[0] == dct_pkg::OFS_CH_SC;
	// shadow of enables; ch1 writes are dropped while buffered, as the design does
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ovIe    <= '0;
			chIe    <= '0;
			bufMode <= '0;
		end else if (busReq.wr) begin
			for (int u = 0; u < 2; u++) begin
				if (ofs[u] == dct_pkg::OFS_MAIN_SC)
					ovIe[u] <= busReq.wdata[dct_pkg::SC_IE];
				if (ofs[u] == dct_pkg::OFS_CH_SC) begin
					chIe[2*u]  <= busReq.wdata[dct_pkg::CS_IE];
					bufMode[u] <= busReq.wdata[dct_pkg::CS_MSB];
				end
				if (ofs[u] == dct_pkg::OFS_CH_SC + dct_pkg::CH_STRIDE && !bufMode[u])
					chIe[2*u+1] <= busReq.wdata[dct_pkg::CS_IE];
			end
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_rst_quiet: assert property ($fell(sys_rst) |-> overflowIrq == 2'h0 && channelIrq == 4'h0)
		else $error("request active after reset");
	chk_trst_reads0: assert property ($past(busReq.rd && ofs[0] == 8'h00) |-> !busRdata[dct_pkg::SC_RST])
		else $error("counter reset bit read as one");
	chk_unmapped_zero: assert property ($past(busReq.rd && (ofs[0] >= 8'h16)) |-> busRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_ch1_released: assert property (bufMode[0] && $past(bufMode[0]) |-> !chPinOe[1] && !channelIrq[1])
		else $error("channel 1 active in buffered mode");
	chk_ch1_read_zero: assert property ($past(busReq.rd && ofs[0] == 8'h08 && bufMode[0]) |-> busRdata == 8'h00)
		else $error("channel 1 register readable in buffered mode");
	chk_ovf_irq_gate: assert property ((overflowIrq & ~ovIe & ~$past(ovIe)) == 2'h0)
		else $error("overflow request without enable");
	chk_chan_irq_gate: assert property ((channelIrq & ~chIe & ~$past(chIe)) == 4'h0)
		else $error("channel request without enable");
	chk_ovf_clear_src: assert property ($fell(overflowIrq[0]) |-> $past(wrMain0) || $past(wrMain0, 2))
		else $error("overflow request dropped without a write");
	chk_ch_clear_src: assert property ($fell(channelIrq[0]) |-> $past(wrCh0) || $past(wrCh0, 2))
		else $error("channel request dropped without a write");
	cover property ($rose(overflowIrq[0]));
	cover property ($rose(channelIrq[0]));
	cover property ($rose(bufMode[0]));
endmodule
bind dct_timer_regs dct_timer_regs_props chk (
	.core_clk    (core_clk),
	.sys_rst     (sys_rst),
	.busReq      (busReq),
	.busRdata    (busRdata),
	.chPinIn     (chPinIn),
	.chPinOut    (chPinOut),
	.chPinOe     (chPinOe),
	.overflowIrq (overflowIrq),
	.channelIrq  (channelIrq)
);
`default_nettype wire

// [dct_pin_model.sv]
`default_nettype none
module dct_pin_model (
	// clock
	input  wire logic       core_clk,
	// bench command, one edge per set bit
	input  wire logic [3:0] flipReq,
	// design pin side
	input  wire logic [3:0] chPinOut,
	input  wire logic [3:0] chPinOe,
	output logic [3:0]      chPinIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] extLevel = 4'h0;
	always @(posedge core_clk) extLevel <= extLevel ^ flipReq;
	// a driven pin shows the design level, otherwise the outside source
	assign chPinIn = (chPinOe & chPinOut) | (~chPinOe & extLevel);
endmodule
`default_nettype wire

// [dct_timer_regs_tb.sv]
`default_nettype none
module dct_timer_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     core_clk = 1'b0;
	logic                     sys_rst  = 1'b1;
	dct_pkg::dct_bus_req_type busReq   = '0;
	logic [7:0]               busRdata;
	logic [3:0]               chPinIn;
	logic [3:0]               chPinOut;
	logic [3:0]               chPinOe;
	logic [1:0]               overflowIrq;
	logic [3:0]               channelIrq;
	logic [3:0]               flipReq  = 4'h0;
	logic [31:0]              seed     = 32'hcc9c;
	logic [7:0]               base;
	logic [7:0]               lim;
	int                       n;
	int                       failures = 0;
	int                       total_checks = 0;

	always #2 core_clk = ~core_clk;

	dct_timer_regs uut (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
		.chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe(chPinOe), .overflowIrq(overflowIrq),
		.channelIrq(channelIrq));
	dct_pin_model pins (.core_clk(core_clk), .flipReq(flipReq), .chPinOut(chPinOut), .chPinOe(chPinOe),
		.chPinIn(chPinIn));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] wrapCount(input logic [7:0] l, input int cyc);
		return 8'(cyc % (int'(l) + 1));
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			failures++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		busReq <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge core_clk);
		busReq <= '0;
		#1 check(busRdata, exp);
	endtask

	// counter runs for exactly cyc edges, then halts; halt stays clear while counting
	task automatic run(input logic [7:0] sc, input int cyc);
		wr(base, sc);
		repeat (cyc - 2) @(posedge core_clk);
		wr(base, sc | 8'h20);
	endtask

	task automatic flip(input logic [3:0] m);
		@(posedge core_clk);
		flipReq <= m;
		@(posedge core_clk);
		flipReq <= 4'h0;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic stop_test();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge core_clk);
		failures++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'h40, 8'h00);
		for (int u = 0; u < 2; u++) begin
			base = u ? dct_pkg::UNIT1_BASE : dct_pkg::UNIT0_BASE;
			rd(base, 8'h20);
			rd(base + 8'h03, 8'hff);
			rd(base + 8'h04, 8'hff);
			wr(base + 8'h02, 8'h5a);
			rd(base + 8'h02, 8'h00);
			for (int ps = 0; ps < 7; ps++) begin
				wr(base, 8'h30 | 8'(ps));
				rd(base + 8'h02, 8'h00);
				run(8'(ps), 4 << ps);
				rd(base, 8'h20 | 8'(ps));
				rd(base + 8'h01, 8'h00);
				rd(base + 8'h02, 8'h04);
			end
		end
		rd(base + 8'h01, 8'h00);
		run(8'h00, 10);
		rd(base + 8'h01, 8'h00);
		rd(base + 8'h02, 8'h04);
		rd(base + 8'h02, 8'h0e);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			lim = {4'h0, seed[3:0]} + 8'h02;
			n = int'(seed[9:4]) + 2;
			wr(base, 8'h30);
			wr(base + 8'h03, 8'h00);
			wr(base + 8'h04, lim);
			run(8'h00, n);
			rd(base + 8'h02, wrapCount(lim, n));
		end
		base = dct_pkg::UNIT0_BASE;
		wr(base, 8'h70);
		wr(base + 8'h03, 8'h00);
		wr(base + 8'h04, 8'h09);
		run(8'h40, 25);
		#1 check({7'h0, overflowIrq[0]}, 8'h01);
		rd(base + 8'h02, 8'h05);
		wr(base, 8'h60);
		rd(base, 8'he0);
		wr(base, 8'he0);
		rd(base, 8'he0);
		wr(base, 8'h60);
		rd(base, 8'h60);
		check({7'h0, overflowIrq[0]}, 8'h00);
		wr(base + 8'h03, 8'h00);
		run(8'h40, 20);
		rd(base, 8'h60);
		wr(base + 8'h04, 8'h09);
		wr(base + 8'h05, 8'h44);
		flip(4'h1);
		#1 check({7'h0, channelIrq[0]}, 8'h01);
		wr(base + 8'h05, 8'h44);
		rd(base + 8'h05, 8'hc4);
		wr(base + 8'h05, 8'h44);
		rd(base + 8'h05, 8'h44);
		flip(4'h1);
		rd(base + 8'h05, 8'h44);
		wr(base + 8'h09, 8'h00);
		wr(base + 8'h0a, 8'h03);
		wr(base + 8'h08, 8'h54);
		wr(base, 8'h30);
		run(8'h00, 10);
		rd(base + 8'h08, 8'hd4);
		check({7'h0, chPinOut[1]}, 8'h00);
		check({7'h0, chPinOe[1]}, 8'h01);
		wr(base + 8'h05, 8'h20);
		rd(base + 8'h08, 8'h00);
		check({7'h0, chPinOe[1]}, 8'h00);
		rd(base + 8'h05, 8'h20);
		wr(dct_pkg::UNIT1_BASE + 8'h08, 8'h20);
		rd(dct_pkg::UNIT1_BASE + 8'h08, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
